// ===== rtl/pdd_pkg.sv
// constants, types and functional notes of the paced parallel transfer engine
// Functional notes
// - a 32-bit input port and a separate 32-bit output port, one bit per channel
// - direct mode lets software read the input and write the output without DMA
// - paced or strobed words move to and from host memory as 32-bit bus master
// - pacer mode samples inputs or updates outputs on each pacer tick, moving words by DMA
// - external clock mode captures one input word per strobe from the peripheral
// - handshake mode moves each word under a request and an acknowledge line
// - input and output paths each buffer through an eight-word FIFO
// - build option IN_EXTRA deepens the base input FIFO itself by that many words, such as 2k
// - build option adds four auxiliary input bits and four auxiliary output bits
// - the three counters run from a fixed 4 MHz time base
// - counter 0 output paces input sampling
// - counter 1 output paces output updates
// - counter 2 can prescale the base clock for counters 0 and 1
// - pacer rate programmable from 0.00093 Hz up to 2 MHz
// - external clock, handshake and strobe transfers sustain up to 3 MHz
// - timer paced transfers sustain up to 2 MHz
// - several interrupt sources, software selects which raise the host interrupt
// - cascaded, input rate is base divided by product of both divisors
// - not cascaded, input rate is base divided by the input divisor alone
package pdd_pkg;
	// ====================================================================
	// timing
	localparam int CORE_HZ = 200_000_000;
	localparam int BASE_HZ = 4_000_000;
	localparam int BASE_DIV = CORE_HZ / BASE_HZ;
	localparam logic [5:0] BASE_DIV_M1 = 6'(BASE_DIV - 1);
	localparam logic [15:0] MIN_DIVISOR = 16'h0002;
	// ====================================================================
	// sizes and steps
	localparam int PORT_W = 32;
	localparam int AUX_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int EXT_DEPTH = 2048;
	localparam int SKID_DEPTH = 2;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	// ====================================================================
	// interrupt sources
	localparam int IRQ_IN_DONE = 0;
	localparam int IRQ_OUT_DONE = 1;
	localparam int IRQ_TRIG = 2;
	localparam int IRQ_OVERRUN = 3;
	localparam int IRQ_W = 4;
	// ====================================================================
	// modes and states, gray along the usual path
	typedef enum logic [1:0] {
		MODE_DIRECT = 2'h0,
		MODE_PACER = 2'h1,
		MODE_EXTCLK = 2'h3,
		MODE_HSHAKE = 2'h2
	} pdd_mode_t;
	typedef enum logic [1:0] {
		OH_IDLE = 2'h0,
		OH_REQ = 2'h1,
		OH_WAIT = 2'h3
	} pdd_ohs_t;
endpackage

// ===== rtl/pdd_stream_if.sv
// valid/ready word stream between the engine's own modules
`timescale 1ns/1ps
interface pdd_stream_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ===== rtl/pdd_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pdd_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	pdd_stream_if.snk wr,
	pdd_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	wire full = (count_reg == FULL_CNT);
	wire empty = (count_reg == '0);
	wire push = wr.valid & ~full;
	wire pop = rd.ready & ~empty;
	assign wr.ready = ~full;
	assign rd.valid = ~empty;
	assign rd.data = mem[rdPtr_reg];
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_reg] <= wr.data;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == LAST_PTR) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == LAST_PTR) ? '0 : rdPtr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	property p_fifo_bound;
		@(posedge core_clk) disable iff (!rst_n)
		full && !pop |=> full && (count_reg == FULL_CNT);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo lost fill state");
endmodule

// ===== rtl/pdd_counter.sv
// programmable divider stage, one output pulse per divisor ticks
`timescale 1ns/1ps
module pdd_counter (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic tick,
	input wire logic [15:0] divisor,
	output logic pulse
);
	logic [15:0] cnt_reg;
	logic pulse_reg;
	// below two the output could not toggle, so the top rate is base / 2
	wire [15:0] effDiv = (divisor < pdd_pkg::MIN_DIVISOR) ? pdd_pkg::MIN_DIVISOR : divisor;
	assign pulse = pulse_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= pdd_pkg::MIN_DIVISOR;
			pulse_reg <= 1'b0;
		end else if (!run) begin
			cnt_reg <= effDiv;
			pulse_reg <= 1'b0;
		end else if (tick && cnt_reg <= 16'h0001) begin
			cnt_reg <= effDiv;
			pulse_reg <= 1'b1;
		end else begin
			cnt_reg <= tick ? cnt_reg - 16'h0001 : cnt_reg;
			pulse_reg <= 1'b0;
		end
	end
	property p_pulse_cause;
		@(posedge core_clk) disable iff (!rst_n)
		pulse_reg |-> $past(tick) && $past(run);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without tick");
endmodule

// ===== rtl/pdd_top.sv
// paced parallel input/output engine with DMA master and handshake pins
`timescale 1ns/1ps
module pdd_top #(
	parameter int PORT_W = 32,
	parameter int AUX_W = 4,
	parameter bit AUX_EN = 1'b0,
	parameter int IN_EXTRA = 0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] modeSel,
	input wire logic inEnable,
	input wire logic outEnable,
	input wire logic trigRequired,
	input wire logic cascadeIn,
	input wire logic cascadeOut,
	input wire logic [15:0] inputDivisor,
	input wire logic [15:0] outputDivisor,
	input wire logic [15:0] prescaleDivisor,
	input wire logic [31:0] inBaseAddr,
	input wire logic [31:0] inWordCount,
	input wire logic [31:0] outBaseAddr,
	input wire logic [31:0] outWordCount,
	input wire logic [pdd_pkg::IRQ_W-1:0] irqSelect,
	input wire logic [pdd_pkg::IRQ_W-1:0] irqClear,
	output logic [pdd_pkg::IRQ_W-1:0] irqStatus,
	output logic hostIrq,
	output logic [PORT_W-1:0] progInData,
	output logic [AUX_W-1:0] progAuxIn,
	input wire logic progOutWrite,
	input wire logic [PORT_W-1:0] progOutData,
	input wire logic [AUX_W-1:0] progAuxOut,
	input wire logic [PORT_W-1:0] inputPort,
	input wire logic [AUX_W-1:0] auxIn,
	input wire logic inReq,
	output logic inAck,
	input wire logic inputStartLine,
	output logic [PORT_W-1:0] outPort,
	output logic [AUX_W-1:0] auxOut,
	output logic outReq,
	input wire logic outAck,
	output logic memWrValid,
	output logic [31:0] memWrAddr,
	output logic [PORT_W-1:0] memWrData,
	input wire logic memWrReady,
	output logic memRdReq,
	output logic [31:0] memRdAddr,
	input wire logic memRdValid,
	input wire logic [PORT_W-1:0] memRdData,
	output logic inDone,
	output logic outDone
);
	localparam int SYNC_W = PORT_W + AUX_W + 3;
	// ====================================================================
	// pin synchronisers
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic reqPrev_reg;
	logic trigPrev_reg;
	// two stages keep the strobe latency near 3 cycles, far below a 3 MHz word period
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			reqPrev_reg <= 1'b0;
			trigPrev_reg <= 1'b0;
		end else begin
			sync1_reg <= {outAck, inputStartLine, inReq, auxIn, inputPort};
			sync2_reg <= sync1_reg;
			reqPrev_reg <= sync2_reg[PORT_W+AUX_W];
			trigPrev_reg <= sync2_reg[PORT_W+AUX_W+1];
		end
	end
	wire [PORT_W-1:0] inSample = sync2_reg[PORT_W-1:0];
	wire [AUX_W-1:0] auxSample = sync2_reg[PORT_W+AUX_W-1:PORT_W];
	wire reqS = sync2_reg[PORT_W+AUX_W];
	wire trigS = sync2_reg[PORT_W+AUX_W+1];
	wire ackS = sync2_reg[PORT_W+AUX_W+2];
	wire reqRise = reqS & ~reqPrev_reg;
	wire trigRise = trigS & ~trigPrev_reg;
	wire isDirect = (modeSel == pdd_pkg::MODE_DIRECT);
	wire isPacer = (modeSel == pdd_pkg::MODE_PACER);
	wire isExt = (modeSel == pdd_pkg::MODE_EXTCLK);
	wire isHs = (modeSel == pdd_pkg::MODE_HSHAKE);
	// ====================================================================
	// time base and pacer counters
	logic [5:0] baseCnt_reg;
	logic baseTick_reg;
	logic c0Pulse;
	logic c1Pulse;
	logic c2Pulse;
	logic inArmed_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			baseCnt_reg <= '0;
			baseTick_reg <= 1'b0;
		end else begin
			baseCnt_reg <= (baseCnt_reg == pdd_pkg::BASE_DIV_M1) ? '0 : baseCnt_reg + 6'h01;
			baseTick_reg <= (baseCnt_reg == pdd_pkg::BASE_DIV_M1);
		end
	end
	wire c0Tick = cascadeIn ? c2Pulse : baseTick_reg;
	wire c1Tick = cascadeOut ? c2Pulse : baseTick_reg;
	pdd_counter u_prescale (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(inEnable | outEnable),
		.tick(baseTick_reg),
		.divisor(prescaleDivisor),
		.pulse(c2Pulse)
	);
	pdd_counter u_in_pacer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(inArmed_reg),
		.tick(c0Tick),
		.divisor(inputDivisor),
		.pulse(c0Pulse)
	);
	pdd_counter u_out_pacer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(outEnable),
		.tick(c1Tick),
		.divisor(outputDivisor),
		.pulse(c1Pulse)
	);
	// ====================================================================
	// input capture
	pdd_stream_if #(.W(PORT_W)) capIf();
	pdd_stream_if #(.W(PORT_W)) inFifoIf();
	pdd_stream_if #(.W(PORT_W)) inSkidIf();
	logic inAck_reg;
	logic overrun_reg;
	logic inDone_reg;
	wire inActive = inArmed_reg & ~isDirect & ~inDone_reg;
	wire hsCapture = isHs & reqS & ~inAck_reg;
	wire strobeEvt = (isPacer & c0Pulse) | (isExt & reqRise);
	wire captureEvt = inActive & (strobeEvt | hsCapture);
	// a strobe cannot be held off, so a word that finds the FIFO full is dropped
	wire dropEvt = inActive & strobeEvt & ~capIf.ready;
	assign capIf.valid = captureEvt;
	assign capIf.data = inSample;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			inArmed_reg <= 1'b0;
			inAck_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (!inEnable || inDone_reg) begin
				inArmed_reg <= 1'b0;
			end else if (!trigRequired || trigRise) begin
				inArmed_reg <= 1'b1;
			end
			if (hsCapture && inActive && capIf.ready) begin
				inAck_reg <= 1'b1;
			end else if (!reqS) begin
				inAck_reg <= 1'b0;
			end
			overrun_reg <= dropEvt;
		end
	end
	pdd_fifo #(.W(PORT_W), .DEPTH(pdd_pkg::FIFO_DEPTH + IN_EXTRA)) u_in_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(capIf),
		.rd(inFifoIf)
	);
	pdd_fifo #(.W(PORT_W), .DEPTH(pdd_pkg::SKID_DEPTH)) u_in_skid (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(inFifoIf),
		.rd(inSkidIf)
	);
	// ====================================================================
	// DMA write master
	logic memWrValid_reg;
	logic [31:0] memWrAddr_reg;
	logic [PORT_W-1:0] memWrData_reg;
	logic [31:0] wrNext_reg;
	logic [31:0] wrLeft_reg;
	wire wrSlot = (~memWrValid_reg | memWrReady) & (wrLeft_reg != '0) & inEnable;
	wire wrTake = wrSlot & inSkidIf.valid;
	assign inSkidIf.ready = wrSlot;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memWrValid_reg <= 1'b0;
			memWrAddr_reg <= '0;
			memWrData_reg <= '0;
			wrNext_reg <= '0;
			wrLeft_reg <= '0;
			inDone_reg <= 1'b0;
		end else if (!inEnable) begin
			memWrValid_reg <= 1'b0;
			wrNext_reg <= inBaseAddr;
			wrLeft_reg <= inWordCount;
			inDone_reg <= 1'b0;
		end else begin
			if (wrTake) begin
				memWrValid_reg <= 1'b1;
				memWrAddr_reg <= wrNext_reg;
				memWrData_reg <= inSkidIf.data;
				wrNext_reg <= wrNext_reg + pdd_pkg::ADDR_STEP;
				wrLeft_reg <= wrLeft_reg - 32'h0000_0001;
			end else if (memWrReady) begin
				memWrValid_reg <= 1'b0;
			end
			inDone_reg <= (wrLeft_reg == '0) & ~memWrValid_reg;
		end
	end
	// ====================================================================
	// DMA read master, one read in flight at a time
	pdd_stream_if #(.W(PORT_W)) rdIf();
	pdd_stream_if #(.W(PORT_W)) outSkidIf();
	pdd_stream_if #(.W(PORT_W)) outFifoIf();
	logic memRdReq_reg;
	logic [31:0] memRdAddr_reg;
	logic [31:0] rdLeft_reg;
	logic rdPend_reg;
	logic outDone_reg;
	pdd_pkg::pdd_ohs_t ohState_reg;
	pdd_pkg::pdd_ohs_t ohState_next;
	// the skid only fills from read returns, so room seen at issue is room at return
	wire rdIssue = outEnable & ~isDirect & (rdLeft_reg != '0) & ~rdPend_reg & rdIf.ready;
	assign rdIf.valid = memRdValid & rdPend_reg;
	assign rdIf.data = memRdData;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memRdReq_reg <= 1'b0;
			memRdAddr_reg <= '0;
			rdLeft_reg <= '0;
			rdPend_reg <= 1'b0;
			outDone_reg <= 1'b0;
		end else if (!outEnable) begin
			memRdReq_reg <= 1'b0;
			memRdAddr_reg <= outBaseAddr;
			rdLeft_reg <= outWordCount;
			rdPend_reg <= 1'b0;
			outDone_reg <= 1'b0;
		end else begin
			memRdReq_reg <= rdIssue;
			if (memRdReq_reg) begin
				memRdAddr_reg <= memRdAddr_reg + pdd_pkg::ADDR_STEP;
			end
			if (rdIssue) begin
				rdPend_reg <= 1'b1;
				rdLeft_reg <= rdLeft_reg - 32'h0000_0001;
			end else if (memRdValid) begin
				rdPend_reg <= 1'b0;
			end
			outDone_reg <= (rdLeft_reg == '0) & ~rdPend_reg & ~outSkidIf.valid
				& ~outFifoIf.valid & (ohState_reg == pdd_pkg::OH_IDLE);
		end
	end
	pdd_fifo #(.W(PORT_W), .DEPTH(pdd_pkg::SKID_DEPTH)) u_out_skid (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(rdIf),
		.rd(outSkidIf)
	);
	pdd_fifo #(.W(PORT_W), .DEPTH(pdd_pkg::FIFO_DEPTH)) u_out_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(outSkidIf),
		.rd(outFifoIf)
	);
	// ====================================================================
	// output update and output handshake
	logic [PORT_W-1:0] outPort_reg;
	logic [AUX_W-1:0] auxOut_reg;
	logic outReq_reg;
	wire outPaced = outEnable & (isPacer | isExt) & c1Pulse;
	wire outHsLoad = outEnable & isHs & (ohState_reg == pdd_pkg::OH_IDLE);
	// with the FIFO empty nothing pops, so the pins keep their last word
	wire outPop = outFifoIf.valid & (outPaced | outHsLoad);
	assign outFifoIf.ready = outPaced | outHsLoad;
	always_comb begin
		ohState_next = ohState_reg;
		case (ohState_reg)
			pdd_pkg::OH_IDLE: begin
				if (outPop && isHs) begin
					ohState_next = pdd_pkg::OH_REQ;
				end
			end
			pdd_pkg::OH_REQ: begin
				if (ackS) begin
					ohState_next = pdd_pkg::OH_WAIT;
				end
			end
			pdd_pkg::OH_WAIT: begin
				if (!ackS) begin
					ohState_next = pdd_pkg::OH_IDLE;
				end
			end
			default: begin
				ohState_next = pdd_pkg::OH_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ohState_reg <= pdd_pkg::OH_IDLE;
			outPort_reg <= '0;
			auxOut_reg <= '0;
			outReq_reg <= 1'b0;
		end else begin
			ohState_reg <= ohState_next;
			outReq_reg <= (ohState_next == pdd_pkg::OH_REQ);
			if (isDirect && progOutWrite) begin
				outPort_reg <= progOutData;
				auxOut_reg <= AUX_EN ? progAuxOut : '0;
			end else if (outPop) begin
				outPort_reg <= outFifoIf.data;
			end
		end
	end
	// ====================================================================
	// program reads and interrupt sources
	logic [PORT_W-1:0] progInData_reg;
	logic [AUX_W-1:0] progAuxIn_reg;
	logic [pdd_pkg::IRQ_W-1:0] irqStatus_reg;
	logic hostIrq_reg;
	logic inDonePrev_reg;
	logic outDonePrev_reg;
	wire [pdd_pkg::IRQ_W-1:0] irqEvt = {overrun_reg, trigRise & inEnable,
		outDone_reg & ~outDonePrev_reg, inDone_reg & ~inDonePrev_reg};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			progInData_reg <= '0;
			progAuxIn_reg <= '0;
			irqStatus_reg <= '0;
			hostIrq_reg <= 1'b0;
			inDonePrev_reg <= 1'b0;
			outDonePrev_reg <= 1'b0;
		end else begin
			progInData_reg <= inSample;
			progAuxIn_reg <= AUX_EN ? auxSample : '0;
			// a new event beats a clear in the same cycle
			irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvt;
			hostIrq_reg <= |(irqStatus_reg & irqSelect);
			inDonePrev_reg <= inDone_reg;
			outDonePrev_reg <= outDone_reg;
		end
	end
	assign irqStatus = irqStatus_reg;
	assign hostIrq = hostIrq_reg;
	assign progInData = progInData_reg;
	assign progAuxIn = progAuxIn_reg;
	assign inAck = inAck_reg;
	assign outPort = outPort_reg;
	assign auxOut = auxOut_reg;
	assign outReq = outReq_reg;
	assign memWrValid = memWrValid_reg;
	assign memWrAddr = memWrAddr_reg;
	assign memWrData = memWrData_reg;
	assign memRdReq = memRdReq_reg;
	assign memRdAddr = memRdAddr_reg;
	assign inDone = inDone_reg;
	assign outDone = outDone_reg;
	// ====================================================================
	// checks
	property p_base_period;
		@(posedge core_clk) disable iff (!rst_n)
		baseTick_reg |-> ##50 baseTick_reg;
	endproperty
	a_base_period: assert property (p_base_period) else $error("base tick period wrong");
	property p_base_gap;
		@(posedge core_clk) disable iff (!rst_n)
		baseTick_reg |=> !baseTick_reg [*8];
	endproperty
	a_base_gap: assert property (p_base_gap) else $error("base tick too close");
	property p_pacer_capture;
		@(posedge core_clk) disable iff (!rst_n)
		inActive && isPacer && c0Pulse && capIf.ready |-> capIf.valid && capIf.data == inSample;
	endproperty
	a_pacer_capture: assert property (p_pacer_capture) else $error("pacer tick missed");
	property p_full_drop;
		@(posedge core_clk) disable iff (!rst_n)
		inActive && isExt && reqRise && !capIf.ready |=> overrun_reg ##1 irqStatus_reg[3];
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("drop not flagged");
	property p_in_ack;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(inAck_reg) |-> $past(capIf.valid && capIf.ready && reqS);
	endproperty
	a_in_ack: assert property (p_in_ack) else $error("ack without capture");
	property p_out_req_hold;
		@(posedge core_clk) disable iff (!rst_n)
		outReq_reg && !ackS |=> outReq_reg && $stable(outPort_reg);
	endproperty
	a_out_req_hold: assert property (p_out_req_hold) else $error("request dropped early");
	property p_out_empty;
		@(posedge core_clk) disable iff (!rst_n)
		!isDirect && $changed(outPort_reg) |-> $past(outFifoIf.valid);
	endproperty
	a_out_empty: assert property (p_out_empty) else $error("update from empty fifo");
	property p_wr_hold;
		@(posedge core_clk) disable iff (!rst_n)
		memWrValid_reg && !memWrReady && inEnable |=> memWrValid_reg && $stable(memWrData_reg)
			&& $stable(memWrAddr_reg);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write word not held");
	property p_wr_step;
		@(posedge core_clk) disable iff (!rst_n)
		inEnable && memWrValid_reg && wrTake |=> memWrAddr_reg == $past(memWrAddr_reg) + 32'h4;
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write address step wrong");
	property p_direct_write;
		@(posedge core_clk) disable iff (!rst_n)
		isDirect && progOutWrite |=> outPort_reg == $past(progOutData);
	endproperty
	a_direct_write: assert property (p_direct_write) else $error("direct write lost");
	property p_irq_mask;
		@(posedge core_clk) disable iff (!rst_n)
		(irqStatus_reg & irqSelect) == '0 |=> !hostIrq_reg;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked source raised irq");
endmodule

// ===== verification/pdd_periph.sv
// peripheral model: word source and sink on the engine's handshake pins
`timescale 1ns/1ps
module pdd_periph (
	input wire logic core_clk,
	input wire logic slow,
	output logic [31:0] inputPort,
	output logic inReq,
	input wire logic inAck,
	input wire logic [31:0] outPort,
	input wire logic outReq,
	output logic outAck
);
	logic [31:0] rxWord [$];
	int holdCnt = 0;
	initial begin
		inputPort = 32'h0;
		inReq = 1'b0;
		outAck = 1'b0;
	end
	// ==========
	// input side
	task automatic show(input logic [31:0] w);
		inputPort <= w;
	endtask
	task automatic send(input logic [31:0] w);
		int n;
		inputPort <= w;
		inReq <= 1'b1;
		for (n = 0; n < 300 && inAck !== 1'b1; n++) @(posedge core_clk);
		inReq <= 1'b0;
		// released data flips so a stale capture shows up
		inputPort <= ~w;
		for (n = 0; n < 300 && inAck !== 1'b0; n++) @(posedge core_clk);
	endtask
	// strobe mode: data settles one edge before the strobe and stays well after it
	task automatic strobe(input logic [31:0] w);
		inputPort <= w;
		@(posedge core_clk);
		inReq <= 1'b1;
		repeat (2) @(posedge core_clk);
		inReq <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	// ==========
	// output side, optionally slow to acknowledge
	always @(posedge core_clk) begin
		if (outReq === 1'b1 && !outAck) begin
			if (holdCnt >= (slow ? 6 : 0)) begin
				rxWord.push_back(outPort);
				outAck <= 1'b1;
				holdCnt <= 0;
			end else begin
				holdCnt <= holdCnt + 1;
			end
		end else if (outReq !== 1'b1) begin
			outAck <= 1'b0;
		end
	end
endmodule

// ===== verification/tb_top.sv
// self-checking bench of the paced transfer engine
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0, rst_n = 1'b0, periphSlow = 1'b0, stallOn = 1'b0;
	logic [1:0] modeSel = 2'h0;
	logic inEnable = 1'b0, outEnable = 1'b0, progOutWrite = 1'b0, cascadeIn = 1'b0;
	logic memWrReady = 1'b1, memRdValid = 1'b0, trigRequired = 1'b0, startLine = 1'b0;
	logic [15:0] inputDivisor = 16'h0002, outputDivisor = 16'h0002, prescaleDivisor = 16'h0002;
	logic [31:0] inBaseAddr = 32'h0, inWordCount = 32'h0, outBaseAddr = 32'h0;
	logic [31:0] outWordCount = 32'h0, progOutData = 32'h0, memRdData = 32'h0;
	logic [3:0] irqSelect = 4'h1, irqClear = 4'h0, irqStatus, progAuxIn, auxOut;
	logic hostIrq, inReq, inAck, outReq, outAck, memWrValid, memRdReq, inDone, outDone;
	logic [31:0] progInData, inputPort, outPort, memWrAddr, memWrData, memRdAddr;
	logic [31:0] wa [$];
	logic [31:0] wd [$];
	int wt [$];
	int cyc = 0, errTotal = 0, checkCount = 0;

	pdd_top pdd_top_i (.core_clk(core_clk), .rst_n(rst_n), .modeSel(modeSel),
		.inEnable(inEnable), .outEnable(outEnable), .trigRequired(trigRequired),
		.cascadeIn(cascadeIn), .cascadeOut(1'b0), .inputDivisor(inputDivisor),
		.outputDivisor(outputDivisor), .prescaleDivisor(prescaleDivisor),
		.inBaseAddr(inBaseAddr), .inWordCount(inWordCount), .outBaseAddr(outBaseAddr),
		.outWordCount(outWordCount), .irqSelect(irqSelect), .irqClear(irqClear),
		.irqStatus(irqStatus), .hostIrq(hostIrq), .progInData(progInData),
		.progAuxIn(progAuxIn), .progOutWrite(progOutWrite), .progOutData(progOutData),
		.progAuxOut(4'hf), .inputPort(inputPort), .auxIn(4'hf), .inReq(inReq),
		.inAck(inAck), .inputStartLine(startLine), .outPort(outPort), .auxOut(auxOut),
		.outReq(outReq), .outAck(outAck), .memWrValid(memWrValid), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .memWrReady(memWrReady), .memRdReq(memRdReq),
		.memRdAddr(memRdAddr), .memRdValid(memRdValid), .memRdData(memRdData),
		.inDone(inDone), .outDone(outDone));
	pdd_periph pdd_periph_i (.core_clk(core_clk), .slow(periphSlow), .inputPort(inputPort),
		.inReq(inReq), .inAck(inAck), .outPort(outPort), .outReq(outReq), .outAck(outAck));

	initial forever #2.5 core_clk = ~core_clk;
	// ==========
	// host memory: one read in flight, writes logged with their cycle
	always @(posedge core_clk) begin
		memRdValid <= memRdReq;
		memRdData <= memRdReq ? (memRdAddr ^ 32'hc3c3_0000) : ~memRdData;
		memWrReady <= stallOn ? ~memWrReady : 1'b1;
		cyc <= cyc + 1;
		if (memWrValid === 1'b1 && memWrReady) begin
			wa.push_back(memWrAddr);
			wd.push_back(memWrData);
			wt.push_back(cyc);
		end
	end
	// ==========
	// helpers
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (errTotal == 0 && checkCount > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_direct();
		pdd_periph_i.show(32'h1234_abcd);
		progOutData <= 32'h5a5a_0001;
		progOutWrite <= 1'b1;
		tick(1);
		progOutWrite <= 1'b0;
		tick(5);
		chk(outPort, 32'h5a5a_0001);
		chk(progInData, 32'h1234_abcd);
		chk(32'(auxOut), 32'h0);
		chk(32'(progAuxIn), 32'h0);
	endtask
	task automatic t_hsIn();
		int n;
		modeSel <= 2'h2;
		inBaseAddr <= 32'h0000_1000;
		inWordCount <= 32'h0000_0003;
		stallOn <= 1'b1;
		tick(2);
		inEnable <= 1'b1;
		for (n = 0; n < 3; n++) pdd_periph_i.send(32'hc0de_0000 + 32'(n));
		for (n = 0; n < 500 && inDone !== 1'b1; n++) tick(1);
		tick(3);
		chk(32'(wa.size()), 32'h3);
		for (n = 0; n < 3; n++) chk(wa[n], 32'h0000_1000 + 32'(4 * n));
		for (n = 0; n < 3; n++) chk(wd[n], 32'hc0de_0000 + 32'(n));
		chk(32'(hostIrq), 32'h1);
		inEnable <= 1'b0;
		stallOn <= 1'b0;
		irqClear <= 4'h1;
		tick(1);
		irqClear <= 4'h0;
		tick(3);
		chk(32'(hostIrq), 32'h0);
	endtask
	task automatic t_pace(input logic casc, input int gap);
		int n;
		wa.delete();
		wd.delete();
		wt.delete();
		modeSel <= 2'h1;
		cascadeIn <= casc;
		inBaseAddr <= 32'h0000_3000;
		inWordCount <= 32'h0000_0002;
		pdd_periph_i.show(32'h0000_00a5);
		tick(4);
		inEnable <= 1'b1;
		for (n = 0; n < 1000 && inDone !== 1'b1; n++) tick(1);
		tick(2);
		chk(32'(wa.size()), 32'h2);
		chk(wd[1], 32'h0000_00a5);
		chk(32'(wt[1] - wt[0]), 32'(gap));
		inEnable <= 1'b0;
		tick(2);
	endtask
	task automatic t_extTrig();
		int n;
		wa.delete();
		wd.delete();
		modeSel <= 2'h3;
		trigRequired <= 1'b1;
		inBaseAddr <= 32'h0000_5000;
		inWordCount <= 32'h0000_0002;
		tick(2);
		inEnable <= 1'b1;
		// strobe before the start line must be ignored
		pdd_periph_i.strobe(32'h0bad_0000);
		startLine <= 1'b1;
		tick(4);
		startLine <= 1'b0;
		pdd_periph_i.strobe(32'h0000_5a01);
		pdd_periph_i.strobe(32'h0000_5a02);
		for (n = 0; n < 200 && inDone !== 1'b1; n++) tick(1);
		chk(32'(wa.size()), 32'h2);
		chk(wd[0], 32'h0000_5a01);
		chk(wd[1], 32'h0000_5a02);
		chk(wa[1], 32'h0000_5004);
		chk(32'(irqStatus[2]), 32'h1);
		inEnable <= 1'b0;
		trigRequired <= 1'b0;
		tick(2);
	endtask
	task automatic t_hsOut();
		int n;
		modeSel <= 2'h2;
		outBaseAddr <= 32'h0000_2000;
		outWordCount <= 32'h0000_0003;
		periphSlow <= 1'b1;
		tick(2);
		outEnable <= 1'b1;
		for (n = 0; n < 2000 && pdd_periph_i.rxWord.size() < 3; n++) tick(1);
		chk(32'(pdd_periph_i.rxWord.size()), 32'h3);
		for (n = 0; n < 3; n++) begin
			chk(pdd_periph_i.rxWord[n], (32'h2000 + 32'(4 * n)) ^ 32'hc3c3_0000);
		end
		tick(12);
		chk(32'(outDone), 32'h1);
		chk(32'(irqStatus[1]), 32'h1);
		outEnable <= 1'b0;
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		tick(10);
		rst_n <= 1'b1;
		tick(2);
		t_direct();
		t_hsIn();
		t_pace(1'b0, pdd_pkg::BASE_DIV * 2);
		t_pace(1'b1, pdd_pkg::BASE_DIV * 4);
		t_extTrig();
		t_hsOut();
		print_verdict();
	end
	initial begin
		#100us;
		errTotal++;
		print_verdict();
	end
endmodule
